// File: inc/rst_seq_pkg.sv
// constants, types and register map of the system reset sequencer
package rst_seq_pkg;
  localparam int          NUM_SRC      = 8;
  localparam int          ADDR_W       = 4;
  // source indices
  localparam int          SRC_POR      = 0;
  localparam int          SRC_PIN      = 1;
  localparam int          SRC_CMP      = 2;
  localparam int          SRC_SW       = 3;
  localparam int          SRC_SUPPLY   = 4;
  localparam int          SRC_WDOG     = 5;
  localparam int          SRC_MCLK     = 6;
  localparam int          SRC_FLASH    = 7;
  // register byte addresses
  localparam logic [3:0]  ADR_CTRL     = 4'h0;
  localparam logic [3:0]  ADR_STATUS   = 4'h4;
  localparam logic [3:0]  ADR_CAUSE    = 4'h8;
  // control bits
  localparam int          CTRL_SWRST   = 0;
  localparam int          CTRL_RETAIN  = 1;
  localparam int          CTRL_WDOG_EN = 2;
  // reset values
  localparam logic [15:0] PC_RESET     = 16'h0000;
  localparam logic [7:0]  PORT_LATCH_RST = 8'hff;
  localparam logic [7:0]  PORT_CFG_RST = 8'h00;
  localparam logic [11:0] DAC_RST      = 12'h000;
  localparam logic [1:0]  CLK_SRC_HFOSC0 = 2'h0;
  localparam logic [2:0]  CLK_DIV_RST  = 3'h3;   // divide by 8
  // hold time in reset, at 125 MHz
  localparam int          HOLD_NS      = 80;
  localparam int          CLK_PERIOD_NS = 8;
  localparam logic [3:0]  HOLD_CYC     =
    4'((HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_HOLD  = 2'b01,
    ST_EXIT  = 2'b11
  } seq_state_e;

  typedef struct packed {
    logic [7:0]  latch;
    logic [7:0]  cfg;
    logic        pullup_en;
  } port_s;

  typedef struct packed {
    logic [1:0]  src;
    logic [2:0]  div;
  } clk_sel_s;
endpackage

// File: hdl/system_reset_sequencer.sv
// system reset sequencer with wishbone register slave
`timescale 1ns/1ps
`default_nettype none
module system_reset_sequencer
  import rst_seq_pkg::*;
(
  input  wire logic              ref_clk_i,
  input  wire logic              rst_b_i,
  input  wire logic              por_i,
  input  wire logic              reset_pin_n_i,
  input  wire logic              cmp_trip_i,
  input  wire logic              supply_low_i,
  input  wire logic              wdog_ovf_i,
  input  wire logic              clk_missing_i,
  input  wire logic              flash_err_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  output logic                   core_halt_o,
  output logic                   sys_reset_o,
  output logic                   irq_enable_o,
  output logic                   timer_enable_o,
  output logic                   ram_enable_o,
  output port_s                  port_o,
  output logic [11:0]            dac_o,
  output logic                   vref_en_o,
  output logic                   reset_pin_n_o,
  output logic                   reset_pin_n_oe_o,
  output logic [15:0]            program_counter_o,
  output clk_sel_s               clk_sel_o,
  output logic                   supervisory_timer_en_o
);

  typedef struct packed {
    seq_state_e          st;
    logic [3:0]          cnt;
    logic [NUM_SRC-1:0]  s1;
    logic [NUM_SRC-1:0]  s2;
    logic [NUM_SRC-1:0]  cause;
    logic                pin_drive;
    logic                pd1;
    logic                pd2;
    logic                swrst;
    logic                retain;
    logic                wdog_en;
    logic                irq_en;
    logic                tmr_en;
    port_s               port;
    logic [11:0]         dac;
    logic                vref;
    logic [15:0]         pc;
    clk_sel_s            clk;
    logic                halt;
    logic                ack;
    logic [31:0]         rdat;
  } state_s;

  state_s r;
  state_s nxt;

  logic [NUM_SRC-1:0] src_raw;
  assign src_raw = {flash_err_i, clk_missing_i, wdog_ovf_i, supply_low_i,
                    1'b0, cmp_trip_i, ~reset_pin_n_i, por_i};

  function automatic logic is_por(input logic [NUM_SRC-1:0] s);
    return s[SRC_POR];
  endfunction

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [3:0] ref_a);
    return a == ref_a;
  endfunction

  logic [NUM_SRC-1:0] req;
  logic               bus_req;

  always_comb begin
    nxt     = r;
    bus_req = wb_cyc_i & wb_stb_i & ~r.ack;
    req     = r.s2;
    req[SRC_SW] = r.swrst;
    // our own pin drive comes back through the synchroniser; without this
    // mask a power-on hold would retrigger itself and never exit
    req[SRC_PIN] = r.s2[SRC_PIN] & ~r.pd2;
    nxt.s1  = src_raw;
    nxt.s2  = r.s1;
    nxt.pd1 = r.pin_drive;
    nxt.pd2 = r.pd1;
    nxt.ack = bus_req;
    // wishbone: one wait state, ack for a single cycle
    nxt.rdat = 32'h0;
    if (bus_req && !wb_we_i) begin
      if (hit(wb_adr_i, ADR_CTRL))
        nxt.rdat = {29'h0, r.wdog_en, r.retain, r.swrst};
      else if (hit(wb_adr_i, ADR_STATUS))
        nxt.rdat = {30'h0, r.halt, r.pin_drive};
      else if (hit(wb_adr_i, ADR_CAUSE))
        nxt.rdat = {24'h0, r.cause};
    end
    if (bus_req && wb_we_i && wb_sel_i[0] && hit(wb_adr_i, ADR_CTRL)) begin
      nxt.swrst   = wb_dat_i[CTRL_SWRST];
      nxt.retain  = wb_dat_i[CTRL_RETAIN];
      nxt.wdog_en = wb_dat_i[CTRL_WDOG_EN];
    end
    unique case (r.st)
      ST_RUN: begin
        nxt.halt = 1'b0;
        nxt.pc   = r.pc + 16'h0001;
        if (|req) begin
          nxt.st    = ST_HOLD;
          nxt.cnt   = HOLD_CYC;
          nxt.cause = req;
        end
      end
      ST_HOLD: begin
        nxt.halt   = 1'b1;
        nxt.irq_en = 1'b0;
        nxt.tmr_en = 1'b0;
        nxt.swrst  = 1'b0;
        nxt.cause  = r.cause | req;
        // reset pin pulled only by supply or power-on, not watchdog
        nxt.pin_drive = r.cause[SRC_SUPPLY] | is_por(r.cause);
        if (!r.retain || is_por(r.cause)) begin
          nxt.port.latch     = PORT_LATCH_RST;
          nxt.port.cfg       = PORT_CFG_RST;
          nxt.port.pullup_en = 1'b1;
          nxt.dac            = DAC_RST;
          nxt.vref           = 1'b0;
        end
        if (is_por(r.cause))
          nxt.retain = 1'b0;
        // stay while any source is still active
        if (|req)
          nxt.cnt = HOLD_CYC;
        else if (r.cnt != 4'h0)
          nxt.cnt = r.cnt - 4'h1;
        else
          nxt.st = ST_EXIT;
      end
      ST_EXIT: begin
        nxt.pin_drive = 1'b0;
        nxt.pc        = PC_RESET;
        nxt.clk.src   = CLK_SRC_HFOSC0;
        nxt.clk.div   = CLK_DIV_RST;
        nxt.wdog_en   = 1'b1;
        nxt.halt      = 1'b0;
        nxt.st        = ST_RUN;
      end
      default: nxt.st = ST_HOLD;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      // external reset acts as power-on
      r           <= '0;
      r.st        <= ST_HOLD;
      r.cnt       <= HOLD_CYC;
      r.cause     <= 8'h01;
      r.halt      <= 1'b1;
      r.pin_drive <= 1'b1;
      r.port      <= '{PORT_LATCH_RST, PORT_CFG_RST, 1'b1};
      r.clk       <= '{CLK_SRC_HFOSC0, CLK_DIV_RST};
    end else begin
      r <= nxt;
    end
  end

  assign wb_dat_o               = r.rdat;
  assign wb_ack_o               = r.ack;
  assign core_halt_o            = r.halt;
  assign sys_reset_o            = r.halt;
  assign irq_enable_o           = r.irq_en;
  assign timer_enable_o         = r.tmr_en;
  assign ram_enable_o           = ~r.halt;
  assign port_o                 = r.port;
  assign dac_o                  = r.dac;
  assign vref_en_o              = r.vref;
  assign reset_pin_n_o          = 1'b0;
  assign reset_pin_n_oe_o       = r.pin_drive;
  assign program_counter_o      = r.pc;
  assign clk_sel_o              = r.clk;
  assign supervisory_timer_en_o = r.wdog_en;

endmodule
`default_nettype wire

// File: bench/reset_pin_model.sv
// reset pin with board pull-up and push button
`timescale 1ns/1ps
`default_nettype none
module reset_pin_model (
  input  wire logic pin_drive_i,
  input  wire logic pin_oe_i,
  input  wire logic button_i,
  output logic      pin_n_o
);
  // released pin floats up through the board pull-up
  assign pin_n_o = (pin_oe_i ? pin_drive_i : 1'b1) & ~button_i;
endmodule
`default_nettype wire

// File: bench/rst_seq_sva.sv
// assertions on the reset sequencer ports
`timescale 1ns/1ps
`default_nettype none
module rst_seq_sva
  import rst_seq_pkg::*;
(
  input wire logic        ref_clk_i,
  input wire logic        rst_b_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic        supply_low_i,
  input wire logic        wdog_ovf_i,
  input wire logic        core_halt_o,
  input wire logic        sys_reset_o,
  input wire logic        irq_enable_o,
  input wire logic        timer_enable_o,
  input wire logic        reset_pin_n_oe_o,
  input wire logic [15:0] program_counter_o,
  input wire clk_sel_s    clk_sel_o,
  input wire logic        supervisory_timer_en_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence held_s; sys_reset_o [*8] ##1 sys_reset_o [*2]; endsequence
  sequence ack_s; wb_ack_o ##1 !wb_ack_o; endsequence
  a_hold_len: assert property ($rose(sys_reset_o) |-> held_s)
    else $error("hold too short");
  a_ack_once: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> ack_s)
    else $error("ack not a single pulse");
  a_halt_sys: assert property (core_halt_o == sys_reset_o)
    else $error("halt differs from reset");
  a_irq_off: assert property (core_halt_o |-> !irq_enable_o && !timer_enable_o)
    else $error("irq or timer on in reset");
  a_supply_pin: assert property ($rose(supply_low_i) |-> ##[1:6] reset_pin_n_oe_o)
    else $error("pin not driven");
  a_wdog_pin: assert property ($rose(wdog_ovf_i) && !supply_low_i &&
    !reset_pin_n_oe_o |-> ##1 !reset_pin_n_oe_o [*6])
    else $error("pin driven on watchdog");
  a_exit_pc: assert property ($fell(sys_reset_o) |->
    ##[0:1] program_counter_o == PC_RESET)
    else $error("pc not cleared");
  a_exit_clk: assert property ($fell(sys_reset_o) |-> ##[0:1] clk_sel_o ==
    {CLK_SRC_HFOSC0, CLK_DIV_RST} && supervisory_timer_en_o)
    else $error("exit defaults wrong");
endmodule
bind system_reset_sequencer rst_seq_sva u_sva (.ref_clk_i(ref_clk_i),
  .rst_b_i(rst_b_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .supply_low_i(supply_low_i), .wdog_ovf_i(wdog_ovf_i),
  .core_halt_o(core_halt_o), .sys_reset_o(sys_reset_o),
  .irq_enable_o(irq_enable_o), .timer_enable_o(timer_enable_o),
  .reset_pin_n_oe_o(reset_pin_n_oe_o), .clk_sel_o(clk_sel_o),
  .program_counter_o(program_counter_o),
  .supervisory_timer_en_o(supervisory_timer_en_o));
`default_nettype wire

// File: bench/testbench.sv
// register and reset source tests of the reset sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import rst_seq_pkg::*;
  logic ref_clk_i, rst_b_i, pin_n, cyc, stb, we, ack, halt, sysr, irq, tmr;
  logic ram, vref, pdrv, poe, wden;
  logic [7:0] src;
  logic [3:0] adr;
  logic [31:0] di, dq, q;
  logic [11:0] dac;
  logic [15:0] pc;
  port_s port;
  clk_sel_s cks;
  int bad_count, n_compared;
  system_reset_sequencer dut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
    .por_i(src[0]), .reset_pin_n_i(pin_n), .cmp_trip_i(src[2]),
    .supply_low_i(src[4]), .wdog_ovf_i(src[5]), .clk_missing_i(src[6]),
    .flash_err_i(src[7]), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(di), .wb_dat_o(dq),
    .wb_ack_o(ack), .core_halt_o(halt), .sys_reset_o(sysr),
    .irq_enable_o(irq), .timer_enable_o(tmr), .ram_enable_o(ram),
    .port_o(port), .dac_o(dac), .vref_en_o(vref), .reset_pin_n_o(pdrv),
    .reset_pin_n_oe_o(poe), .program_counter_o(pc), .clk_sel_o(cks),
    .supervisory_timer_en_o(wden));
  reset_pin_model pin (.pin_drive_i(pdrv), .pin_oe_i(poe),
    .button_i(src[1]), .pin_n_o(pin_n));
  initial begin
    ref_clk_i = 0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end
  task automatic final_report;
    if (bad_count == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n = 0;
    cyc <= 1; stb <= 1; we <= w; adr <= a; di <= d;
    do begin @(posedge ref_clk_i); n++; end while (ack !== 1'b1 && n < 20);
    if (n >= 20) begin bad_count++; final_report; end
    q = dq; cyc <= 0; stb <= 0;
    @(posedge ref_clk_i);
  endtask
  task automatic wait_for(input logic v);
    int n = 0;
    while (sysr !== v && n < 200) begin @(posedge ref_clk_i); n++; end
    if (n >= 200) begin bad_count++; final_report; end
  endtask
  initial begin
    rst_b_i = 0; src = 0; cyc = 0; stb = 0; we = 0; adr = 0; di = 0;
    repeat (5) @(posedge ref_clk_i);
    rst_b_i <= 1;
    wait_for(0);
    chk("clk_sel", {CLK_SRC_HFOSC0, CLK_DIV_RST}, cks);
    chk("wdog_en", 1, wden);
    chk("irq_tmr", 0, {irq, tmr});
    chk("port", {PORT_LATCH_RST, PORT_CFG_RST, 1'b1}, port);
    chk("ram_vref_dac", {1'b1, 1'b0, DAC_RST}, {ram, vref, dac});
    bus(0, ADR_CAUSE, 0); chk("cause", 1, q);
    bus(0, 4'hc, 0); chk("unmapped", 0, q);
    for (int i = 0; i < NUM_SRC; i++) begin
      if (i == 1) bus(1, ADR_CTRL, 32'h2);
      if (i == SRC_SW) bus(1, ADR_CTRL, 32'h3);
      else src <= 8'h1 << i;
      wait_for(1);
      chk("halt", 1, halt);
      chk("pin_oe", i == SRC_POR || i == SRC_SUPPLY, poe);
      src <= 0;
      wait_for(0);
      bus(0, ADR_CAUSE, 0);
      chk("cause", 1 << i, q & ((i % 4 == 0) ? 1 << i : 'hff));
    end
    bus(0, ADR_CTRL, 0); chk("retain", 2, q & 2);
    src <= 1; wait_for(1); src <= 0; wait_for(0);
    bus(0, ADR_CTRL, 0); chk("retain", 0, q & 2);
    final_report;
  end
endmodule
`default_nettype wire
